// file: core/torque_limiter_regs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef TORQUE_LIMITER_REGS_SVH
`define TORQUE_LIMITER_REGS_SVH

// ==========================================
// Register byte offsets
`define OFS_LIMIT_SRC    12'h000
`define OFS_SETPOINT     12'h004
`define OFS_MARGIN       12'h008
`define OFS_LAG_TIME     12'h00c
`define OFS_LEVELS       12'h010
`define OFS_FUNCTIONS    12'h014
`define OFS_STATUS       12'h018
`define OFS_TORQUE       12'h01c
`define OFS_LIMITS       12'h020

// ==========================================
// Field positions
`define LVL13_LSB        0
`define LVL16_LSB        2
`define LVL14_LSB        4
`define FN16_LSB         0
`define FN14_LSB         8

// ==========================================
// Reset values and ranges
`define SRC_ANALOG       2'h1
`define SRC_SETPOINT     2'h2
`define RST_SETPOINT     8'h00
`define SETPOINT_MAX     8'h78
`define SETPOINT_MIN     8'h88
`define RST_MARGIN       7'h0a
`define MARGIN_MAX       7'h78
`define RST_LAG_TIME     11'h000
`define LAG_TIME_MAX     11'h3e8
`define RST_LVL13        2'h0
`define RST_LVL16        2'h0
`define RST_LVL14        2'h2
`define RST_FN16         5'h1f
`define RST_FN14         5'h1f
`define FN_TORQUE_REF    5'h13
`define FN_TORQUE_COMP   5'h14
`define FN_FREQ_REF      5'h1f
`define PCT_SCALE        8'h0a

// ==========================================
// Timing
`define CLK_MHZ          20
`define CTRL_PERIOD_US   1000
`define CTRL_TICK_CYCLES (`CTRL_PERIOD_US * `CLK_MHZ)

`endif

// file: core/torque_limiter_pkg.sv
// Types shared by the torque-mode speed limiter
package torque_limiter_pkg;

  // Analog value, 0.1 % of full scale per count
  typedef logic signed [15:0] pct_t;

  // Input signal level selection
  typedef enum logic [1:0] {
    LVL_UNIPOLAR,
    LVL_BIPOLAR,
    LVL_CURRENT
  } level_e;

endpackage

// file: core/lag_filter.sv
// First-order lag filter for the torque reference
`timescale 1ns/1ns
`default_nettype none

module lag_filter #(
  parameter int W  = 16,
  parameter int FB = 8
) (
  input  wire logic                pclk,     // Clock
  input  wire logic                presetn,  // Async reset, low
  input  wire logic                tick,     // Control-cycle pulse
  input  wire logic [10:0]         tau_ms,   // Time constant in ms
  input  wire logic signed [W-1:0] x,        // Filter input
  output logic signed [W-1:0]      y         // Filter output
);

  logic signed [W+FB-1:0] acc;
  logic signed [W+FB-1:0] next_acc;
  logic signed [W+FB:0]   diff;
  logic signed [W+FB:0]   step;

  // ==========================================
  // Next accumulator value
  always_comb begin
    diff     = $signed({x[W-1], x, {FB{1'b0}}}) - $signed({acc[W+FB-1], acc});
    // Full-width quotient, then cut; divisor is at least one here, two when tau_ms is nonzero
    step     = diff / $signed({2'b00, tau_ms} + 13'sd1);
    next_acc = acc;
    if (tau_ms == 11'h000) begin
      next_acc = {x, {FB{1'b0}}};
    end else if (tick) begin
      next_acc = acc + step[W+FB-1:0];
    end
  end

  // Accumulator register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc <= '0;
    end else begin
      acc <= next_acc;
    end
  end

  assign y = acc[W+FB-1:FB];

endmodule // lag_filter

`default_nettype wire

// file: core/torque_limiter.sv
// Torque-mode speed limiter with APB configuration registers
`timescale 1ns/1ns
`default_nettype none
`include "torque_limiter_regs.svh"

// Notes on behaviour
// - Source 1 analog inputs, 2 stored setpoint
// - Analog source uses voltage terminal 13
// - Terminal 14 at 1F adds to limit
// - Analog sign and run direction choose side
// - Zero bias clamps opposite side to zero
// - Setpoint signed -120..+120 percent, default 0
// - Setpoint sign and run direction choose side
// - Bias 0..120 percent, default 10
// - Range from minus bias to limit plus bias
// - Torque reference passes first-order lag filter
// - Function 14 terminal adds torque compensation
// - Levels: unipolar, bipolar, 4-20 mA only 14
// - Compensation sign alone sets its direction
// - Unipolar levels give forward-only compensation
// - Settings refused while drive is running
// - Function 13 terminal supplies torque reference
// - Overspeed adds opposing torque proportional excess
module torque_limiter #(
  parameter int TICK_CYCLES  = `CTRL_TICK_CYCLES,
  parameter int SUPPR_SHIFT  = 0
) (
  input  wire logic                        pclk,           // Clock 20 MHz
  input  wire logic                        presetn,        // Async reset, low
  input  wire logic                        psel,           // APB select
  input  wire logic                        penable,        // APB enable
  input  wire logic                        pwrite,         // APB direction
  input  wire logic [11:0]                 paddr,          // APB byte address
  input  wire logic [31:0]                 pwdata,         // APB write data
  output logic                             pready,         // APB ready
  output logic                             pslverr,        // APB error
  output logic [31:0]                      prdata,         // APB read data
  input  wire logic                        run_cmd,        // Drive running pin
  input  wire logic                        run_reverse,    // Reverse run pin
  input  wire torque_limiter_pkg::pct_t    ain13,          // Terminal 13 value
  input  wire torque_limiter_pkg::pct_t    ain14,          // Terminal 14 value
  input  wire torque_limiter_pkg::pct_t    ain16,          // Terminal 16 value
  input  wire torque_limiter_pkg::pct_t    motor_speed,    // Measured speed
  output torque_limiter_pkg::pct_t         torque_cmd,     // Torque command
  output logic signed [18:0]               speed_limit_hi, // Upper speed bound
  output logic signed [18:0]               speed_limit_lo, // Lower speed bound
  output logic                             speed_limiting  // Suppression active
);
  import torque_limiter_pkg::*;

  // ==========================================
  // Input synchronisers
  logic [65:0] sync1;
  logic [65:0] sync2;
  logic        running;
  logic        reverse;
  pct_t        a13;
  pct_t        a14;
  pct_t        a16;
  pct_t        spd;

  // Two-stage capture of pin inputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= {run_cmd, run_reverse, ain13, ain14, ain16, motor_speed};
      sync2 <= sync1;
    end
  end

  assign {running, reverse, a13, a14, a16, spd} = sync2;

  // ==========================================
  // Configuration registers
  logic [1:0]        limit_src;
  logic signed [7:0] setpoint;
  logic [6:0]        margin;
  logic [10:0]       lag_time;
  logic [1:0]        lvl13;
  logic [1:0]        lvl16;
  logic [1:0]        lvl14;
  logic [4:0]        fn16;
  logic [4:0]        fn14;
  logic [1:0]        next_limit_src;
  logic signed [7:0] next_setpoint;
  logic [6:0]        next_margin;
  logic [10:0]       next_lag_time;
  logic [1:0]        next_lvl13;
  logic [1:0]        next_lvl16;
  logic [1:0]        next_lvl14;
  logic [4:0]        next_fn16;
  logic [4:0]        next_fn14;
  logic              next_pready;
  logic              next_pslverr;
  logic [31:0]       next_prdata;
  logic              commit;
  logic              wr_bad;
  logic              mapped;

  // Write checks and read mux
  always_comb begin
    mapped      = 1'b1;
    wr_bad      = 1'b0;
    next_prdata = 32'h0000_0000;
    case (paddr)
      `OFS_LIMIT_SRC: begin
        next_prdata = {30'h0, limit_src};
        wr_bad = (pwdata[1:0] != `SRC_ANALOG) && (pwdata[1:0] != `SRC_SETPOINT);
      end
      `OFS_SETPOINT: begin
        next_prdata = {{24{setpoint[7]}}, setpoint};
        wr_bad = ($signed(pwdata[7:0]) > $signed(`SETPOINT_MAX))
              || ($signed(pwdata[7:0]) < $signed(`SETPOINT_MIN));
      end
      `OFS_MARGIN: begin
        next_prdata = {25'h0, margin};
        wr_bad = pwdata[6:0] > `MARGIN_MAX;
      end
      `OFS_LAG_TIME: begin
        next_prdata = {21'h0, lag_time};
        wr_bad = pwdata[10:0] > `LAG_TIME_MAX;
      end
      `OFS_LEVELS: begin
        next_prdata = {26'h0, lvl14, lvl16, lvl13};
        // Current level only on terminal 14
        wr_bad = (pwdata[`LVL13_LSB +: 2] > LVL_BIPOLAR)
              || (pwdata[`LVL16_LSB +: 2] > LVL_BIPOLAR)
              || (pwdata[`LVL14_LSB +: 2] > LVL_CURRENT);
      end
      `OFS_FUNCTIONS: begin
        next_prdata = {19'h0, fn14, 3'h0, fn16};
        wr_bad = pwdata[`FN14_LSB +: 5] == 5'h00;
      end
      `OFS_STATUS: begin
        next_prdata = {29'h0, speed_limiting, reverse, running};
        wr_bad = 1'b1;
      end
      `OFS_TORQUE: begin
        next_prdata = {{16{torque_cmd[15]}}, torque_cmd};
        wr_bad = 1'b1;
      end
      `OFS_LIMITS: begin
        next_prdata = {speed_limit_hi[15:0], speed_limit_lo[15:0]};
        wr_bad = 1'b1;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
    if (pwrite) begin
      next_prdata = 32'h0000_0000;
    end
    next_pready  = psel && penable && !pready;
    next_pslverr = next_pready && (!mapped || (pwrite && (wr_bad || running)));
  end

  assign commit = psel && penable && pready && pwrite && !pslverr;

  // Register write values
  always_comb begin
    next_limit_src = limit_src;
    next_setpoint  = setpoint;
    next_margin    = margin;
    next_lag_time  = lag_time;
    next_lvl13     = lvl13;
    next_lvl16     = lvl16;
    next_lvl14     = lvl14;
    next_fn16      = fn16;
    next_fn14      = fn14;
    if (commit) begin
      case (paddr)
        `OFS_LIMIT_SRC: next_limit_src = pwdata[1:0];
        `OFS_SETPOINT:  next_setpoint  = pwdata[7:0];
        `OFS_MARGIN:    next_margin    = pwdata[6:0];
        `OFS_LAG_TIME:  next_lag_time  = pwdata[10:0];
        `OFS_LEVELS: begin
          next_lvl13 = pwdata[`LVL13_LSB +: 2];
          next_lvl16 = pwdata[`LVL16_LSB +: 2];
          next_lvl14 = pwdata[`LVL14_LSB +: 2];
        end
        `OFS_FUNCTIONS: begin
          next_fn16 = pwdata[`FN16_LSB +: 5];
          next_fn14 = pwdata[`FN14_LSB +: 5];
        end
        default: begin
        end
      endcase
    end
  end

  // Register and bus answer flip-flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      limit_src <= `SRC_ANALOG;
      setpoint  <= `RST_SETPOINT;
      margin    <= `RST_MARGIN;
      lag_time  <= `RST_LAG_TIME;
      lvl13     <= `RST_LVL13;
      lvl16     <= `RST_LVL16;
      lvl14     <= `RST_LVL14;
      fn16      <= `RST_FN16;
      fn14      <= `RST_FN14;
      pready    <= 1'b0;
      pslverr   <= 1'b0;
      prdata    <= 32'h0000_0000;
    end else begin
      limit_src <= next_limit_src;
      setpoint  <= next_setpoint;
      margin    <= next_margin;
      lag_time  <= next_lag_time;
      lvl13     <= next_lvl13;
      lvl16     <= next_lvl16;
      lvl14     <= next_lvl14;
      fn16      <= next_fn16;
      fn14      <= next_fn14;
      pready    <= next_pready;
      pslverr   <= next_pslverr;
      prdata    <= next_pready ? next_prdata : 32'h0000_0000;
    end
  end

  // ==========================================
  // Analog conditioning
  function automatic pct_t level_clip(input pct_t v, input logic [1:0] lvl);
    level_clip = (lvl == LVL_BIPOLAR || !v[15]) ? v : 16'sh0000;
  endfunction

  pct_t c13;
  pct_t c14;
  pct_t c16;

  assign c13 = level_clip(a13, lvl13);
  assign c14 = level_clip(a14, lvl14);
  assign c16 = level_clip(a16, lvl16);

  // ==========================================
  // Speed limit window
  logic signed [18:0] lim_mag;
  logic signed [18:0] lim_dir;
  logic signed [18:0] bias;
  logic signed [18:0] next_hi;
  logic signed [18:0] next_lo;

  // Limit source, direction and bias
  always_comb begin
    if (limit_src == `SRC_SETPOINT) begin
      // Widen before the product so 120 % times ten cannot wrap
      lim_mag = 19'(setpoint) * $signed(19'(`PCT_SCALE));
    end else begin
      lim_mag = 19'(c13);
      if (fn14 == `FN_FREQ_REF) begin
        lim_mag = 19'(c13) + 19'(c14);
      end
    end
    lim_dir = reverse ? -lim_mag : lim_mag;
    bias    = $signed(19'(margin)) * $signed(19'(`PCT_SCALE));
    if (!lim_dir[18]) begin
      next_hi = lim_dir + bias;
      next_lo = -bias;
    end else begin
      next_hi = bias;
      next_lo = lim_dir - bias;
    end
  end

  // ==========================================
  // Torque path
  logic [15:0]        tick_cnt;
  logic [15:0]        next_tick_cnt;
  logic               tick;
  pct_t               tref_raw;
  pct_t               tref_filt;
  pct_t               tcomp;
  logic signed [19:0] excess;
  logic signed [19:0] suppress;
  logic signed [19:0] tsum;
  pct_t               next_torque;
  logic               next_limiting;

  // Control-cycle divider
  always_comb begin
    tick          = tick_cnt == 16'(TICK_CYCLES - 1);
    next_tick_cnt = tick ? 16'h0000 : tick_cnt + 16'h0001;
  end

  // Reference and compensation selection
  always_comb begin
    tref_raw = 16'sh0000;
    tcomp    = 16'sh0000;
    if (fn16 == `FN_TORQUE_REF) begin
      tref_raw = c16;
    end else if (fn14 == `FN_TORQUE_REF) begin
      tref_raw = c14;
    end
    // Sign of the clipped input sets the direction
    if (fn16 == `FN_TORQUE_COMP) begin
      tcomp = c16;
    end else if (fn14 == `FN_TORQUE_COMP) begin
      tcomp = c14;
    end
  end

  lag_filter #(
    .W  (16),
    .FB (8)
  ) u_filter (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (tick),
    .tau_ms  (lag_time),
    .x       (tref_raw),
    .y       (tref_filt)
  );

  // Overspeed suppression and saturation
  always_comb begin
    excess = 20'sh00000;
    if (19'(spd) > speed_limit_hi) begin
      excess = 20'(19'(spd) - speed_limit_hi);
    end else if (19'(spd) < speed_limit_lo) begin
      excess = 20'(19'(spd) - speed_limit_lo);
    end
    suppress      = -(excess >>> SUPPR_SHIFT);
    next_limiting = excess != 20'sh00000;
    tsum          = 20'(tref_filt) + 20'(tcomp) + suppress;
    if (tsum > 20'sh07fff) begin
      next_torque = 16'sh7fff;
    end else if (tsum < -20'sh08000) begin
      next_torque = -16'sh8000;
    end else begin
      next_torque = tsum[15:0];
    end
  end

  // Output registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt       <= 16'h0000;
      speed_limit_hi <= '0;
      speed_limit_lo <= '0;
      torque_cmd     <= '0;
      speed_limiting <= 1'b0;
    end else begin
      tick_cnt       <= next_tick_cnt;
      speed_limit_hi <= next_hi;
      speed_limit_lo <= next_lo;
      torque_cmd     <= next_torque;
      speed_limiting <= next_limiting;
    end
  end

endmodule // torque_limiter

`default_nettype wire

// file: verification/torque_limiter_checker.sv
// Concurrent checks on the torque limiter ports
`timescale 1ns/1ns
`default_nettype none
`include "torque_limiter_regs.svh"
// ==========================================
// Checker
module torque_limiter_checker (
  input wire logic               pclk,           // Clock
  input wire logic               presetn,        // Reset, low
  input wire logic               psel,           // APB select
  input wire logic               penable,        // APB enable
  input wire logic               pwrite,         // APB direction
  input wire logic [11:0]        paddr,          // APB address
  input wire logic [31:0]        pwdata,         // APB write data
  input wire logic               pready,         // APB ready
  input wire logic               pslverr,        // APB error
  input wire logic [31:0]        prdata,         // APB read data
  input wire logic               run_cmd,        // Running pin
  input wire logic signed [18:0] speed_limit_hi, // Upper bound
  input wire logic signed [18:0] speed_limit_lo  // Lower bound
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Write completing at this edge
  wire wr = psel && penable && pwrite && pready;
  sequence s_wait; psel && penable && !pready; endsequence
  sequence s_ans; pready ##1 !pready; endsequence
  sequence s_running; run_cmd [*5]; endsequence
  property p_ready_wait; s_wait |=> s_ans; endproperty
  a_ready_wait: assert property (p_ready_wait) else $error("ready not after one wait");
  property p_rdata_idle; !pready |-> prdata == 32'h0; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside answer");
  property p_err_ready; pslverr |-> pready; endproperty
  a_err_ready: assert property (p_err_ready) else $error("error without ready");
  property p_window; speed_limit_lo <= 0 && speed_limit_hi >= 0; endproperty
  a_window: assert property (p_window) else $error("window excludes zero");
  property p_run_refuse; s_running ##0 wr |-> pslverr; endproperty
  a_run_refuse: assert property (p_run_refuse) else $error("write taken while running");
  property p_src_range;
    wr && paddr == `OFS_LIMIT_SRC && pwdata[1:0] != 2'h1 && pwdata[1:0] != 2'h2 |-> pslverr;
  endproperty
  a_src_range: assert property (p_src_range) else $error("bad source accepted");
  property p_sp_range;
    wr && paddr == `OFS_SETPOINT && ($signed(pwdata[7:0]) > 120 || $signed(pwdata[7:0]) < -120)
      |-> pslverr;
  endproperty
  a_sp_range: assert property (p_sp_range) else $error("bad setpoint accepted");
  property p_margin_range; wr && paddr == `OFS_MARGIN && pwdata[6:0] > 7'h78 |-> pslverr;
  endproperty
  a_margin_range: assert property (p_margin_range) else $error("bad margin accepted");
  property p_lag_range; wr && paddr == `OFS_LAG_TIME && pwdata[10:0] > 11'h3e8 |-> pslverr;
  endproperty
  a_lag_range: assert property (p_lag_range) else $error("bad lag accepted");
  property p_level_range;
    wr && paddr == `OFS_LEVELS && (pwdata[1:0] > 1 || pwdata[3:2] > 1 || pwdata[5:4] > 2)
      |-> pslverr;
  endproperty
  a_level_range: assert property (p_level_range) else $error("bad level accepted");
endmodule // torque_limiter_checker

bind torque_limiter torque_limiter_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .prdata(prdata), .run_cmd(run_cmd), .speed_limit_hi(speed_limit_hi),
  .speed_limit_lo(speed_limit_lo));
`default_nettype wire

// file: verification/host_ctrl_model.sv
// Host controller model driving run state and analog references
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// Host model
module host_ctrl_model (
  input  wire logic                pclk,        // Clock
  output logic                     run_cmd,     // Running pin
  output logic                     run_reverse, // Reverse pin
  output torque_limiter_pkg::pct_t ain13,       // Terminal 13
  output torque_limiter_pkg::pct_t ain14,       // Terminal 14
  output torque_limiter_pkg::pct_t ain16,       // Terminal 16
  output torque_limiter_pkg::pct_t motor_speed  // Measured speed
);
  import torque_limiter_pkg::*;
  // Idle host: stopped, all references zero
  initial begin
    {run_cmd, run_reverse} = 2'h0;
    {ain13, ain14, ain16, motor_speed} = 64'h0;
  end
  // Values held stable until the next call, as the per-bit syncs need
  task automatic drive(input logic r, v, input int a, b, c, s);
    @(posedge pclk);
    run_cmd     <= r;
    run_reverse <= v;
    ain13       <= 16'(a);
    ain14       <= 16'(b);
    ain16       <= 16'(c);
    motor_speed <= 16'(s);
  endtask
endmodule // host_ctrl_model
`default_nettype wire

// file: verification/tb_torque_limiter.sv
// Self-checking bench for the torque-mode speed limiter
`timescale 1ns/1ns
`default_nettype none
`include "torque_limiter_regs.svh"
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("mismatch %s expected %0d seen %0d", n, e, g); end end
// ==========================================
// Bench top
module tb_torque_limiter;
  import torque_limiter_pkg::*;
  logic               pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic               run_cmd, run_reverse, speed_limiting;
  logic [11:0]        paddr;
  logic [31:0]        pwdata, prdata, rd;
  pct_t               ain13, ain14, ain16, motor_speed, torque_cmd;
  logic signed [18:0] speed_limit_hi, speed_limit_lo;
  int n_mismatch, total_checks, src, sp, mg, lg, l13, l16, l14, f16, f14, rev;
  int a13, a14, a16, eh, el, et;
  int rst_tab[6] = '{1, 0, 10, 0, 'h20, 'h1f1f};
  int fn_tab[4][2] = '{'{'h13, 'h14}, '{'h14, 'h13}, '{0, 'h1f}, '{'h13, 'h1f}};
  int bad_tab[12][3] = '{'{0, 3, 1}, '{4, 'h79, 1}, '{4, 'h87, 1}, '{8, 121, 1},
    '{'hc, 1001, 1}, '{'h10, 2, 1}, '{'h14, 0, 1}, '{4, 'h88, 0}, '{4, 'h78, 0},
    '{8, 120, 0}, '{'hc, 1000, 0}, '{'h18, 0, 1}};

  host_ctrl_model u_host (.pclk(pclk), .run_cmd(run_cmd), .run_reverse(run_reverse),
    .ain13(ain13), .ain14(ain14), .ain16(ain16), .motor_speed(motor_speed));
  torque_limiter #(.TICK_CYCLES(10), .SUPPR_SHIFT(0)) u_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .pslverr(pslverr), .prdata(prdata), .run_cmd(run_cmd),
    .run_reverse(run_reverse), .ain13(ain13), .ain14(ain14), .ain16(ain16),
    .motor_speed(motor_speed), .torque_cmd(torque_cmd), .speed_limit_hi(speed_limit_hi),
    .speed_limit_lo(speed_limit_lo), .speed_limiting(speed_limiting));

  // Clock, 50 ns period
  initial begin
    pclk = 0;
    forever #25 pclk = ~pclk;
  end
  // One APB transfer, held until ready is sampled
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin @(posedge pclk); t++; end while (pready !== 1'b1 && t < 20);
    if (t >= 20) n_mismatch++;
    rd = prdata; err = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task automatic wr(input logic [11:0] a, input int d, input int e);
    apb(1, a, 32'(d));
    `CHK("pslverr", e, 32'(err))
  endtask
  task automatic cfg();
    wr(`OFS_LIMIT_SRC, src, 0);
    wr(`OFS_SETPOINT, sp & 255, 0);
    wr(`OFS_MARGIN, mg, 0);
    wr(`OFS_LAG_TIME, lg, 0);
    wr(`OFS_LEVELS, l13 | l16 << 2 | l14 << 4, 0);
    wr(`OFS_FUNCTIONS, f16 | f14 << 8, 0);
  endtask
  function automatic int clip(int v, int lv);
    return (lv != 1 && v < 0) ? 0 : v;
  endfunction
  // Reference window and torque from the current settings
  task automatic model();
    int c13, c14, c16, L;
    c13 = clip(a13, l13); c14 = clip(a14, l14); c16 = clip(a16, l16);
    L = (src == 2) ? sp * 10 : c13 + (f14 == 'h1f ? c14 : 0);
    if (rev) L = -L;
    eh = (L >= 0) ? L + mg * 10 : mg * 10;
    el = (L >= 0) ? -mg * 10 : L - mg * 10;
    et = (f16 == 'h13 ? c16 : f14 == 'h13 ? c14 : 0) + (f16 == 'h14 ? c16 : f14 == 'h14 ? c14 : 0);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (60000) @(posedge pclk);
    n_mismatch++;
    print_verdict();
  end
  // Main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
    n_mismatch = 0; total_checks = 0;
    void'($urandom(61));
    repeat (16) @(posedge pclk);
    presetn <= 1;
    for (int k = 0; k < 6; k++) begin
      apb(0, 12'(k * 4), 0);
      `CHK("reset value", rst_tab[k], rd)
    end
    apb(0, 12'h024, 0);
    `CHK("unmapped", 1, 32'(err))
    `CHK("reset hi", 100, 32'(speed_limit_hi))
    `CHK("reset lo", -100, 32'(speed_limit_lo))
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      src = 1 + i % 2; sp = $urandom_range(240) - 120; mg = $urandom_range(120); lg = 0;
      l13 = $urandom % 2; l16 = $urandom % 2; l14 = $urandom % 3; rev = $urandom % 2;
      f16 = fn_tab[i % 4][0]; f14 = fn_tab[i % 4][1];
      a13 = $urandom_range(2000) - 1000;
      if (l13 == 0 && a13 < 0) a13 = -a13;
      a14 = $urandom_range(2000) - 1000; a16 = $urandom_range(2000) - 1000;
      cfg();
      model();
      u_host.drive(1, rev, a13, a14, a16, 0);
      repeat (6) @(posedge pclk);
      `CHK("hi", eh, 32'(speed_limit_hi))
      `CHK("lo", el, 32'(speed_limit_lo))
      `CHK("torque", et, 32'(torque_cmd))
      `CHK("limiting", 0, 32'(speed_limiting))
      apb(0, `OFS_LIMITS, 0);
      `CHK("limits reg", {eh[15:0], el[15:0]}, rd)
      u_host.drive(1, rev, a13, a14, a16, eh + 37);
      repeat (6) @(posedge pclk);
      `CHK("limiting", 1, 32'(speed_limiting))
      `CHK("suppressed", et - 37, 32'(torque_cmd))
      u_host.drive(0, rev, a13, a14, a16, 0);
      repeat (4) @(posedge pclk);
    end
    $display("test window done");
    u_host.drive(1, 0, 0, 0, 0, 0);
    repeat (6) @(posedge pclk);
    wr(`OFS_MARGIN, 5, 1);
    apb(0, `OFS_STATUS, 0);
    `CHK("status", 1, rd)
    u_host.drive(0, 0, 0, 0, 0, 0);
    repeat (5) @(posedge pclk);
    apb(0, `OFS_MARGIN, 0);
    `CHK("margin kept", mg, rd)
    for (int k = 0; k < 12; k++) begin
      wr(12'(bad_tab[k][0]), bad_tab[k][1], bad_tab[k][2]);
    end
    $display("test refuse done");
    src = 2; sp = 0; mg = 10; lg = 5; l13 = 0; l16 = 1; l14 = 2; f16 = 'h13; f14 = 'h1f;
    cfg();
    u_host.drive(0, 0, 0, 0, 600, 0);
    repeat (4) @(posedge pclk);
    `CHK("lag slow", 1, 32'(torque_cmd < 600))
    repeat (400) @(posedge pclk);
    `CHK("lag settle", 1, 32'(torque_cmd > 590 && torque_cmd <= 600))
    $display("test lag done");
    print_verdict();
  end
endmodule // tb_torque_limiter
`default_nettype wire
